// ==== rtl/cmp_defs.svh ====
// Register offsets, field positions and reset values of the comparator control block.
`ifndef CMP_DEFS_SVH
`define CMP_DEFS_SVH

// ----------------------------------------------------------------------------
// Widths
// ----------------------------------------------------------------------------
`define CMP_ADDR_W        8
`define CMP_DATA_W        8
`define CMP_LEVEL_W       8
`define CMP_PINS          5

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define OFS_INTERRUPT_CTRL  8'h0B
`define OFS_PERIPH_FLAG     8'h0C
`define OFS_COMPARATOR_CTRL 8'h1F
`define OFS_PORT_A_DATA     8'h05
`define OFS_PORT_A_DIR      8'h85
`define OFS_PERIPH_ENABLE   8'h8C

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define BIT_SECOND_RESULT   7
`define BIT_FIRST_RESULT    6
`define BIT_INPUT_SWITCH    3
`define BIT_GLOBAL_IRQ_EN   7
`define BIT_PERIPH_IRQ_EN   6
`define BIT_CHANGE_FLAG     6
`define BIT_CHANGE_ENABLE   6

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define RST_INTERRUPT_CTRL  8'h00
`define RST_COMPARATOR_CTRL 4'h0
`define RST_PORT_A_DIR      5'h1F
`define RST_PORT_A_LATCH    5'h00

`endif

// ==== rtl/cmp_pkg.sv ====
// Types shared by the comparator control block and its helpers.
`include "cmp_defs.svh"
package cmp_pkg;
  // Digital model of one analog level.
  typedef logic [`CMP_LEVEL_W-1:0] level_t;
  // Levels of the five port pins, index = pin number.
  typedef level_t [`CMP_PINS-1:0] level_bank_t;
  // The eight operating configurations, numbered in field order.
  typedef enum logic [2:0] {
    MODE_RESET,
    MODE_THREE_IN,
    MODE_FOUR_IN_VREF,
    MODE_COMMON_REF,
    MODE_INDEPENDENT,
    MODE_SINGLE,
    MODE_PIN_OUT,
    MODE_OFF
  } cmp_mode_t;
endpackage

// ==== rtl/cmp_route_if.sv ====
// Bundle between the control logic and the comparator input router.
`timescale 1ns/10ps
`default_nettype none
`include "cmp_defs.svh"
interface cmp_route_if;
  import cmp_pkg::*;
  cmp_mode_t              mode;     // Selected configuration.
  logic                   switch;   // Inverting input switch.
  level_bank_t            level;    // Synchronised pin levels.
  level_t                 vref;     // Synchronised reference level.
  logic [1:0]             result;   // Comparator outputs, bit 0 = first.
  logic [`CMP_PINS-1:0]   analog;   // Pins held as analog inputs.
  modport ctrl (output mode, output switch, output level, output vref,
                input result, input analog);
  modport router (input mode, input switch, input level, input vref,
                  output result, output analog);
endinterface
`default_nettype wire

// ==== rtl/cmp_router.sv ====
// Input routing and comparison for both comparators; the reset and off modes turn both off, the single mode the first.
`timescale 1ns/10ps
`default_nettype none
module cmp_router (
  cmp_route_if.router rif
);
  import cmp_pkg::*;

  // --------------------------------------------------------------------------
  // Pick the plus and minus levels per mode, then compare.
  // --------------------------------------------------------------------------
  // Equal levels give a low output; the real part is uncertain there anyway.
  always_comb begin
    level_t p1, m1, p2, m2;
    logic   on1, on2;
    p1 = rif.level[2];
    m1 = rif.level[0];
    p2 = rif.level[2];
    m2 = rif.level[1];
    on1 = 1'b1;
    on2 = 1'b1;
    rif.analog = 5'h0F;
    case (rif.mode)
      MODE_RESET: begin
        on1 = 1'b0;
        on2 = 1'b0;
      end
      MODE_THREE_IN: begin
        m1 = rif.switch ? rif.level[3] : rif.level[0];
      end
      MODE_FOUR_IN_VREF: begin
        p1 = rif.vref;
        p2 = rif.vref;
        m1 = rif.switch ? rif.level[3] : rif.level[0];
        m2 = rif.switch ? rif.level[2] : rif.level[1];
      end
      MODE_COMMON_REF: rif.analog = 5'h07;
      MODE_INDEPENDENT: p1 = rif.level[3];
      MODE_SINGLE: begin
        on1 = 1'b0;
        rif.analog = 5'h06;
      end
      MODE_PIN_OUT: rif.analog = 5'h07;
      MODE_OFF: begin
        on1 = 1'b0;
        on2 = 1'b0;
        rif.analog = 5'h00;
      end
      default: begin
        on1 = 1'b0;
        on2 = 1'b0;
      end
    endcase
    rif.result[0] = on1 && (p1 > m1);
    rif.result[1] = on2 && (p2 > m2);
  end
endmodule // cmp_router
`default_nettype wire

// ==== rtl/cmp_sync.sv ====
// Two-flop synchroniser for a bundle of pin inputs.
`timescale 1ns/10ps
`default_nettype none
module cmp_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  // --------------------------------------------------------------------------
  // One two-stage chain per bit; the first stage feeds only the second.
  // --------------------------------------------------------------------------
  for (genvar i = 0; i < W; i++) begin : g_bit
    logic meta_q;  // First stage, may go metastable.
    logic hold_q;  // Second stage, safe to use.
    always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
        meta_q <= 1'b0;
        hold_q <= 1'b0;
      end else begin
        meta_q <= async_in[i];
        hold_q <= meta_q;
      end
    end
    assign sync_out[i] = hold_q;
  end
endmodule // cmp_sync
`default_nettype wire

// ==== rtl/dual_comparator_control.sv ====
// Register file, change detection, interrupt gating and pin muxing of the dual comparator.
`timescale 1ns/10ps
`default_nettype none
`include "cmp_defs.svh"
module dual_comparator_control (
  input  wire logic                       clk,
  input  wire logic                       sys_rst,
  input  wire logic [`CMP_ADDR_W-1:0]     reg_addr,
  input  wire logic                       reg_wr,
  input  wire logic                       reg_rd,
  input  wire logic [`CMP_DATA_W-1:0]     reg_wdata,
  output logic      [`CMP_DATA_W-1:0]     reg_rdata,
  input  wire cmp_pkg::level_bank_t       pin_level,
  input  wire cmp_pkg::level_t            vref_level,
  input  wire logic [`CMP_PINS-1:0]       pin_in,
  output logic      [`CMP_PINS-1:0]       pin_out,
  output logic      [`CMP_PINS-1:0]       pin_oe_n,
  output logic                            irq_req
);
  import cmp_pkg::*;

  // --------------------------------------------------------------------------
  // Input synchronisation
  // --------------------------------------------------------------------------
  // All pin levels, the reference and the digital pin inputs cross together.
  // Each level word is synchronised bit by bit, so a level that moves while
  // it is sampled may appear torn for one cycle and show as a brief glitch.
  // Sources are expected to move slowly against the core clock.
  localparam int SYNC_W = (`CMP_PINS + 1) * `CMP_LEVEL_W + `CMP_PINS;

  logic [SYNC_W-1:0]    sync_raw;   // Bundle before the synchroniser.
  logic [SYNC_W-1:0]    sync_val;   // Bundle after the synchroniser.
  level_bank_t          lvl_s;      // Synchronised pin levels.
  level_t               vref_s;     // Synchronised reference level.
  logic [`CMP_PINS-1:0] pin_in_s;   // Synchronised digital pin levels.

  assign sync_raw = {pin_level, vref_level, pin_in};
  assign {lvl_s, vref_s, pin_in_s} = sync_val;

  cmp_sync #(
    .W (SYNC_W)
  ) u_sync (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .async_in (sync_raw),
    .sync_out (sync_val)
  );

  // --------------------------------------------------------------------------
  // Register state
  // --------------------------------------------------------------------------
  logic [`CMP_DATA_W-1:0] intctl_q, intctl_d;   // Interrupt control byte.
  logic [3:0]             cmpctl_q, cmpctl_d;   // Switch and mode field.
  logic [`CMP_PINS-1:0]   dir_q, dir_d;         // Port direction, 1 = input.
  logic [`CMP_PINS-1:0]   latch_q, latch_d;     // Port output latch.
  logic                   flag_q, flag_d;       // Change flag.
  logic                   enable_q, enable_d;   // Change interrupt enable.
  logic [1:0]             seen_q, seen_d;       // Results at last access.
  logic [`CMP_DATA_W-1:0] rdata_q, rdata_d;     // Read data register.
  logic [`CMP_PINS-1:0]   pout_q, pout_d;       // Pin output register.
  logic [`CMP_PINS-1:0]   poe_n_q, poe_n_d;     // Pin enable register.
  logic                   irq_q, irq_d;         // Interrupt request register.

  // --------------------------------------------------------------------------
  // Router connection
  // --------------------------------------------------------------------------
  cmp_route_if rif ();

  assign rif.mode   = cmp_mode_t'(cmpctl_q[2:0]);
  assign rif.switch = cmpctl_q[`BIT_INPUT_SWITCH];
  assign rif.level  = lvl_s;
  assign rif.vref   = vref_s;

  cmp_router u_router (
    .rif (rif)
  );

  // --------------------------------------------------------------------------
  // Access decode
  // --------------------------------------------------------------------------
  logic cmp_access; // Any read or write of the comparator control register.
  logic mismatch;   // Current results differ from the last-seen copy.
  logic flag_set;   // Hardware sets the change flag this cycle.

  assign cmp_access = (reg_wr || reg_rd) && (reg_addr == `OFS_COMPARATOR_CTRL);
  assign mismatch   = (rif.result != seen_q);
  // A change coinciding with a control read compares against the copy that is
  // being reloaded, so it is absorbed and no flag results.
  assign flag_set   = mismatch && !cmp_access;

  // --------------------------------------------------------------------------
  // Writable registers next state
  // --------------------------------------------------------------------------
  // Writes show one cycle after the strobe; result bits take no write.
  always_comb begin
    intctl_d = intctl_q;
    cmpctl_d = cmpctl_q;
    dir_d    = dir_q;
    latch_d  = latch_q;
    enable_d = enable_q;
    if (reg_wr) begin
      case (reg_addr)
        `OFS_INTERRUPT_CTRL:  intctl_d = reg_wdata;
        `OFS_COMPARATOR_CTRL: cmpctl_d = reg_wdata[3:0];
        `OFS_PORT_A_DIR:      dir_d = reg_wdata[`CMP_PINS-1:0];
        `OFS_PORT_A_DATA:     latch_d = reg_wdata[`CMP_PINS-1:0];
        `OFS_PERIPH_ENABLE:   enable_d = reg_wdata[`BIT_CHANGE_ENABLE];
        default:              intctl_d = intctl_q;
      endcase
    end
  end

  // Control state returns to mode 000 so every comparator pin is analog.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      intctl_q <= `RST_INTERRUPT_CTRL;
      cmpctl_q <= `RST_COMPARATOR_CTRL;
      dir_q    <= `RST_PORT_A_DIR;
      latch_q  <= `RST_PORT_A_LATCH;
      enable_q <= 1'b0;
    end else begin
      intctl_q <= intctl_d;
      cmpctl_q <= cmpctl_d;
      dir_q    <= dir_d;
      latch_q  <= latch_d;
      enable_q <= enable_d;
    end
  end

  // --------------------------------------------------------------------------
  // Change detection and flag
  // --------------------------------------------------------------------------
  // The copy reloads on every control access, ending a standing mismatch.
  // Until then the mismatch keeps setting the flag, so a clear only sticks
  // once software has touched the control register first.
  always_comb begin
    seen_d = cmp_access ? rif.result : seen_q;
    flag_d = flag_q;
    // Writing one raises the flag as if a change had been seen.
    if (reg_wr && (reg_addr == `OFS_PERIPH_FLAG)) begin
      flag_d = reg_wdata[`BIT_CHANGE_FLAG];
    end
    if (flag_set) begin
      flag_d = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      seen_q <= 2'h0;
      flag_q <= 1'b0;
    end else begin
      seen_q <= seen_d;
      flag_q <= flag_d;
    end
  end

  // --------------------------------------------------------------------------
  // Read data
  // --------------------------------------------------------------------------
  // Reads answer one cycle after the strobe; unmapped offsets return zero.
  // Port reads see the pins through the synchroniser, two cycles late, so a
  // latch write reads back on a driven pin only a few cycles afterwards.
  always_comb begin
    rdata_d = rdata_q;
    if (reg_rd) begin
      case (reg_addr)
        `OFS_INTERRUPT_CTRL:  rdata_d = intctl_q;
        `OFS_COMPARATOR_CTRL: rdata_d = {rif.result[1], rif.result[0],
                                         2'b00, cmpctl_q};
        `OFS_PORT_A_DIR:      rdata_d = {3'b000, dir_q};
        `OFS_PORT_A_DATA:     rdata_d = {3'b000, pin_in_s & ~rif.analog};
        `OFS_PERIPH_FLAG:     rdata_d = {1'b0, flag_q, 6'h00};
        `OFS_PERIPH_ENABLE:   rdata_d = {1'b0, enable_q, 6'h00};
        default:              rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // --------------------------------------------------------------------------
  // Pin drive and interrupt request
  // --------------------------------------------------------------------------
  // In the pin-output mode the results replace the latch on pins A3 and A4.
  // They pass one register here, the price of a glitch-free pin output.
  // Direction bits pass unchanged through a matching register to the enables, so a pin set as input is
  // never driven even while its output carries a result.
  always_comb begin
    pout_d  = latch_q;
    poe_n_d = dir_q;
    if (rif.mode == MODE_PIN_OUT) begin
      pout_d[3] = rif.result[0];
      pout_d[4] = rif.result[1];
    end
    irq_d = flag_q && enable_q && intctl_q[`BIT_PERIPH_IRQ_EN]
            && intctl_q[`BIT_GLOBAL_IRQ_EN];
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pout_q  <= `RST_PORT_A_LATCH;
      poe_n_q <= `RST_PORT_A_DIR;
      irq_q   <= 1'b0;
    end else begin
      pout_q  <= pout_d;
      poe_n_q <= poe_n_d;
      irq_q   <= irq_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign pin_out   = pout_q;
  assign pin_oe_n  = poe_n_q;
  assign irq_req   = irq_q;

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  // All checks share the core clock and are switched off while reset is high.
  // Result checks compare against the synchronised levels, not the raw pins.

  common_ref_cmp_a: assert property (
    (rif.mode == MODE_COMMON_REF) |-> (rif.result[0] == (lvl_s[2] > lvl_s[0])))
    else $error("first comparator polarity wrong");

  result_readback_a: assert property (
    (reg_rd && reg_addr == `OFS_COMPARATOR_CTRL)
    |=> (reg_rdata[7:6] == $past(rif.result)))
    else $error("result bits read back wrong");

  unimpl_zero_a: assert property (
    (reg_rd && reg_addr == `OFS_COMPARATOR_CTRL) |=> (reg_rdata[5:4] == 2'b00))
    else $error("unimplemented bits not zero");

  mode_store_a: assert property (
    (reg_wr && reg_addr == `OFS_COMPARATOR_CTRL)
    |=> (cmpctl_q == $past(reg_wdata[3:0])))
    else $error("mode field not stored");

  switch_route_a: assert property (
    (rif.mode == MODE_THREE_IN && rif.switch)
    |-> (rif.result[0] == (lvl_s[2] > lvl_s[3])))
    else $error("switch did not route pin A3");

  vref_route_a: assert property (
    (rif.mode == MODE_FOUR_IN_VREF && !rif.switch)
    |-> (rif.result[1] == (vref_s > lvl_s[1])))
    else $error("reference not on plus input");

  pin_out_a: assert property (
    (rif.mode == MODE_PIN_OUT) |=> (pin_out[4:3] == $past(rif.result)))
    else $error("pins not driven by results");

  dir_gate_a: assert property (
    ##1 (pin_oe_n == $past(dir_q)))
    else $error("direction bits not gating drivers");

  analog_read_a: assert property (
    (reg_rd && reg_addr == `OFS_PORT_A_DATA && rif.analog[0])
    |=> (reg_rdata[0] == 1'b0))
    else $error("analog pin read nonzero");

  flag_set_a: assert property (
    flag_set |=> flag_q [*1] ##0 (seen_q == $past(seen_q)))
    else $error("change did not set flag");

  irq_gate_a: assert property (
    irq_req |-> $past(flag_q && enable_q && intctl_q[7] && intctl_q[6]))
    else $error("request without all enables");

  mismatch_end_a: assert property (
    cmp_access |=> (seen_q == $past(rif.result)))
    else $error("access did not end mismatch");

  // In the four-input mode a set switch moves the minus inputs from A0 and A1 to A3 and A2.
  switch_pair_a: assert property (
    (rif.mode == MODE_FOUR_IN_VREF && rif.switch)
    |-> (rif.result[1] == (vref_s > lvl_s[2])))
    else $error("switch did not route pin A2");

  // The reference also feeds the first comparator in that mode.
  vref_first_a: assert property (
    (rif.mode == MODE_FOUR_IN_VREF && rif.switch)
    |-> (rif.result[0] == (vref_s > lvl_s[3])))
    else $error("reference not on first plus input");

  // The reset and off modes keep both results low.
  modes_off_a: assert property (
    (rif.mode == MODE_RESET || rif.mode == MODE_OFF)
    |-> (rif.result == 2'b00))
    else $error("disabled comparator drove a result");

  // Software writes reach the flag unless a change sets it in the same cycle.
  flag_write_a: assert property (
    (reg_wr && reg_addr == `OFS_PERIPH_FLAG && !flag_set)
    |=> (flag_q == $past(reg_wdata[`BIT_CHANGE_FLAG])))
    else $error("flag write not obeyed");

  // A pending flag with every enable set raises the request next cycle.
  irq_raise_a: assert property (
    (flag_q && enable_q && intctl_q[`BIT_PERIPH_IRQ_EN] && intctl_q[`BIT_GLOBAL_IRQ_EN])
    |=> irq_req)
    else $error("request missing with all enables set");

  // A control access swallows a coinciding change instead of flagging it.
  access_absorb_a: assert property (
    (cmp_access && !flag_q) |=> !flag_q)
    else $error("change during control access set the flag");

  // Leaving reset the mode field is zero and every pin driver is off.
  reset_mode_a: assert property (
    $fell(sys_rst) |-> (cmpctl_q == `RST_COMPARATOR_CTRL && pin_oe_n == `RST_PORT_A_DIR))
    else $error("reset state not restored");
endmodule // dual_comparator_control
`default_nettype wire

// ==== test/analog_source.sv ====
// Behavioural model of the analog pins, the reference and the digital pin levels.
`timescale 1ns/10ps
`default_nettype none
module analog_source (
  input  wire logic [4:0]     pin_out,
  input  wire logic [4:0]     pin_oe_n,
  output cmp_pkg::level_bank_t pin_level,
  output cmp_pkg::level_t     vref_level,
  output logic      [4:0]     pin_in
);
  import cmp_pkg::*;
  // ---------------------------------------------------------------
  // Levels
  // ---------------------------------------------------------------
  // All levels start at mid scale, so every comparison starts equal.
  initial begin
    pin_level = {5{8'h80}};
    vref_level = 8'h80;
  end
  // Changes one pin level; called just after a rising clock edge.
  task automatic set_pin(input int idx, input level_t v);
    pin_level[idx] <= v;
  endtask
  // Changes the reference level.
  task automatic set_vref(input level_t v);
    vref_level <= v;
  endtask
  // A driven pin shows the driver's value; an undriven one reads its level's top bit.
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      pin_in[i] = pin_oe_n[i] ? pin_level[i][7] : pin_out[i];
    end
  end
endmodule // analog_source
`default_nettype wire

// ==== test/testbench.sv ====
// Self-checking bench for the dual comparator control block.
`timescale 1ns/10ps
`default_nettype none
`include "cmp_defs.svh"
module testbench;
  import cmp_pkg::*;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic        clk;         // Core clock, 4 ns period.
  logic        sys_rst;     // Reset, active high.
  logic [7:0]  reg_addr;    // Register offset.
  logic        reg_wr;      // Write strobe.
  logic        reg_rd;      // Read strobe.
  logic [7:0]  reg_wdata;   // Write data.
  logic [7:0]  reg_rdata;   // Read data.
  level_bank_t pin_level;   // Pin levels from the source model.
  level_t      vref_level;  // Reference level.
  logic [4:0]  pin_in;      // Digital pin levels.
  logic [4:0]  pin_out;     // Pin output data.
  logic [4:0]  pin_oe_n;    // Pin driver enables, low drives.
  logic        irq_req;     // Interrupt request.
  int          errors;      // Mismatches seen.
  int          comparisons; // Checks made.
  // Mode writes and the control value expected back with the test levels.
  logic [7:0] cfg [6] = '{8'h01, 8'h09, 8'h02, 8'h0A, 8'h04, 8'h05};
  logic [7:0] res [6] = '{8'hC1, 8'h89, 8'hC2, 8'h0A, 8'hC4, 8'h85};
  // Modes and the port value expected when analog pins read zero.
  logic [7:0] pm [3] = '{8'h00, 8'h07, 8'h05};
  logic [7:0] pe [3] = '{8'h10, 8'h1E, 8'h18};

  dual_comparator_control uut (
    .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .pin_level(pin_level), .vref_level(vref_level), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe_n(pin_oe_n), .irq_req(irq_req));
  analog_source src (
    .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_level(pin_level),
    .vref_level(vref_level), .pin_in(pin_in));

  // Free-running clock.
  initial clk = 1'b0;
  always #2 clk = ~clk;
  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  // Compares one value and reports a mismatch at once.
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One-cycle write strobe; the gap cycle keeps strobes from merging.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // One-cycle read strobe; data is registered, so it is taken after the next edge.
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Prints the verdict and ends the run.
  task automatic complete_run();
    if (errors == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Cuts a hang short; the tests need well under a thousand cycles.
  initial begin
    idle(2000);
    errors++;
    complete_run();
  end
  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial begin
    sys_rst = 1'b1;
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
    errors = 0;
    comparisons = 0;
    idle(16);
    sys_rst <= 1'b0;
    rd(`OFS_COMPARATOR_CTRL, 8'h00);
    rd(`OFS_PORT_A_DIR, 8'h1F);
    rd(`OFS_INTERRUPT_CTRL, 8'h00);
    rd(8'h40, 8'h00);
    chk({3'h0, pin_oe_n}, 8'h1F);
    // Equal levels keep both results low; writes try to set the read-only bits.
    for (int m = 0; m < 8; m++) begin
      wr(`OFS_COMPARATOR_CTRL, 8'hF0 | m[7:0]);
      rd(`OFS_COMPARATOR_CTRL, m[7:0]);
    end
    @(posedge clk);
    src.set_pin(0, 8'h70);
    src.set_pin(2, 8'h90);
    src.set_pin(3, 8'hA0);
    src.set_pin(4, 8'hFF);
    src.set_vref(8'h88);
    idle(4);
    // The two switch settings of modes 1 and 2 pick distinct inputs, so their results differ.
    for (int i = 0; i < 6; i++) begin
      wr(`OFS_COMPARATOR_CTRL, cfg[i]);
      rd(`OFS_COMPARATOR_CTRL, res[i]);
    end
    for (int i = 0; i < 3; i++) begin
      wr(`OFS_COMPARATOR_CTRL, pm[i]);
      rd(`OFS_PORT_A_DATA, pe[i]);
    end
    // Output routing: the latch holds zero, so ones come from the results.
    wr(`OFS_PORT_A_DIR, 8'h07);
    wr(`OFS_COMPARATOR_CTRL, 8'h06);
    idle(2);
    chk({3'h0, pin_oe_n}, 8'h07);
    chk({6'h0, pin_out[4:3]}, 8'h03);
    // The latch still sets pin_out on the low pins, whose drivers are off, while the results own A3 and A4.
    wr(`OFS_PORT_A_DATA, 8'h05);
    idle(2);
    chk({3'h0, pin_out}, 8'h1D);
    wr(`OFS_COMPARATOR_CTRL, 8'h03);
    idle(2);
    chk({6'h0, pin_out[4:3]}, 8'h00);
    wr(`OFS_PORT_A_DIR, 8'h1F);
    idle(2);
    chk({3'h0, pin_oe_n}, 8'h1F);
    // Change detection with every enable set.
    wr(`OFS_PERIPH_ENABLE, 8'h40);
    rd(`OFS_COMPARATOR_CTRL, 8'hC3);
    wr(`OFS_PERIPH_FLAG, 8'h00);
    rd(`OFS_PERIPH_FLAG, 8'h00);
    wr(`OFS_INTERRUPT_CTRL, 8'hC0);
    @(posedge clk);
    src.set_pin(0, 8'hA0);
    idle(6);
    rd(`OFS_PERIPH_FLAG, 8'h40);
    chk({7'h0, irq_req}, 8'h01);
    // Clearing before the control access fails: the mismatch sets it again.
    wr(`OFS_PERIPH_FLAG, 8'h00);
    rd(`OFS_PERIPH_FLAG, 8'h40);
    rd(`OFS_COMPARATOR_CTRL, 8'h83);
    wr(`OFS_PERIPH_FLAG, 8'h00);
    rd(`OFS_PERIPH_FLAG, 8'h00);
    chk({7'h0, irq_req}, 8'h00);
    // Software-set flag and enable gating.
    wr(`OFS_INTERRUPT_CTRL, 8'h40);
    wr(`OFS_PERIPH_FLAG, 8'h40);
    rd(`OFS_PERIPH_FLAG, 8'h40);
    chk({7'h0, irq_req}, 8'h00);
    wr(`OFS_INTERRUPT_CTRL, 8'hC0);
    idle(2);
    chk({7'h0, irq_req}, 8'h01);
    wr(`OFS_PERIPH_ENABLE, 8'h00);
    idle(2);
    chk({7'h0, irq_req}, 8'h00);
    wr(`OFS_PERIPH_ENABLE, 8'h40);
    wr(`OFS_INTERRUPT_CTRL, 8'h80);
    idle(2);
    chk({7'h0, irq_req}, 8'h00);
    rd(`OFS_INTERRUPT_CTRL, 8'h80);
    // Mask interrupts, turn the comparators off, then reset in mid-run.
    wr(`OFS_INTERRUPT_CTRL, 8'h00);
    wr(`OFS_COMPARATOR_CTRL, 8'h07);
    @(posedge clk);
    sys_rst <= 1'b1;
    idle(2);
    sys_rst <= 1'b0;
    rd(`OFS_COMPARATOR_CTRL, 8'h00);
    rd(`OFS_PORT_A_DIR, 8'h1F);
    complete_run();
  end
endmodule // testbench
`default_nettype wire
